// ### bstc_consts.svh
// Constants for the sensing wait timing configuration block
`ifndef BSTC_CONSTS_SVH
`define BSTC_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define BSTC_ADDR_CTRL 8'h26
`define BSTC_ADDR_DRIVE_WINDOW 8'h27
`define BSTC_ADDR_SENSE_WAIT_TIMES 8'h28
`define BSTC_ADDR_STATUS 8'h2a
`define BSTC_ADDR_RESULT 8'h2b

// ****************************************
// Field positions
// ****************************************
`define BSTC_SETTLE_MSB 7
`define BSTC_SETTLE_LSB 4
`define BSTC_DISCH_MSB 3
`define BSTC_DISCH_LSB 0
`define BSTC_DRIVE_MSB 4
`define BSTC_DRIVE_LSB 0
`define BSTC_CTRL_RMM_BIT 0
`define BSTC_CTRL_CONT_BIT 1
`define BSTC_CTRL_START_BIT 2
`define BSTC_STAT_BUSY_BIT 0
`define BSTC_STAT_STATE_MSB 3
`define BSTC_STAT_STATE_LSB 1
`define BSTC_STAT_READY_BIT 4
`define BSTC_STAT_CFGERR_BIT 5

// ****************************************
// Reset values
// ****************************************
`define BSTC_RST_SETTLE_CODE 4'h1
`define BSTC_RST_DISCH_CODE 4'h1
`define BSTC_RST_DRIVE_CODE 5'h0a

// ****************************************
// Timing
// ****************************************
`define BSTC_CLK_HZ 10000000
`define BSTC_CYC_PER_US (`BSTC_CLK_HZ / 1000000)
`define BSTC_DRIVE_STEP_US 100
`define BSTC_DRIVE_STEP_CYC (`BSTC_DRIVE_STEP_US * `BSTC_CYC_PER_US)
`define BSTC_DRIVE_CODE_OFFSET 5
`define BSTC_RMM_DRIVE_MULT 2
`define BSTC_RES_US_0 9'd15
`define BSTC_RES_US_1 9'd25
`define BSTC_RES_US_2 9'd50
`define BSTC_RES_US_3 9'd75
`define BSTC_RES_US_4 9'd90
`define BSTC_RES_US_5 9'd105
`define BSTC_RES_US_6 9'd120
`define BSTC_RES_US_7 9'd135
`define BSTC_RES_US_8 9'd150
`define BSTC_RES_US_9 9'd165
`define BSTC_RES_US_10 9'd180
`define BSTC_RES_US_11 9'd195
`define BSTC_RES_US_12 9'd210
`define BSTC_RES_US_13 9'd235
`define BSTC_RES_US_14 9'd260
`define BSTC_RES_US_15 9'd285
`define BSTC_RMM_US_0 9'd45
`define BSTC_RMM_US_1 9'd75
`define BSTC_RMM_US_2 9'd150
`define BSTC_RMM_US_3 9'd225

`endif

// ### bstc_pkg.sv
// Types shared by the sensing wait timing configuration block
package bstc_pkg;

  typedef enum logic [2:0] {
    BSTC_IDLE = 3'b000,
    BSTC_DRIVE = 3'b001,
    BSTC_DISCHARGE = 3'b010,
    BSTC_SETTLE = 3'b011,
    BSTC_SAMPLE = 3'b100
  } bstc_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bstc_bus_req_s;

endpackage : bstc_pkg

// ### bstc_wait_lut.sv
// Wait code to cycle count lookup for one sensing wait field
`timescale 1ns/1ps
`include "bstc_consts.svh"

module bstc_wait_lut (
  input logic [3:0] code_in,
  input logic rotating_mass_mode_in,
  output logic [11:0] wait_cycles_out,
  output logic illegal_out
);

  logic [8:0] wait_us;

  always_comb begin
    wait_us = `BSTC_RES_US_0;
    if (rotating_mass_mode_in) begin
      // Undefined codes clamp to the longest defined delay
      unique case (code_in[1:0])
        2'h0: wait_us = code_in[3:2] == 2'h0 ? `BSTC_RMM_US_0 : `BSTC_RMM_US_3;
        2'h1: wait_us = code_in[3:2] == 2'h0 ? `BSTC_RMM_US_1 : `BSTC_RMM_US_3;
        2'h2: wait_us = code_in[3:2] == 2'h0 ? `BSTC_RMM_US_2 : `BSTC_RMM_US_3;
        2'h3: wait_us = `BSTC_RMM_US_3;
      endcase
    end else begin
      unique case (code_in)
        4'h0: wait_us = `BSTC_RES_US_0;
        4'h1: wait_us = `BSTC_RES_US_1;
        4'h2: wait_us = `BSTC_RES_US_2;
        4'h3: wait_us = `BSTC_RES_US_3;
        4'h4: wait_us = `BSTC_RES_US_4;
        4'h5: wait_us = `BSTC_RES_US_5;
        4'h6: wait_us = `BSTC_RES_US_6;
        4'h7: wait_us = `BSTC_RES_US_7;
        4'h8: wait_us = `BSTC_RES_US_8;
        4'h9: wait_us = `BSTC_RES_US_9;
        4'ha: wait_us = `BSTC_RES_US_10;
        4'hb: wait_us = `BSTC_RES_US_11;
        4'hc: wait_us = `BSTC_RES_US_12;
        4'hd: wait_us = `BSTC_RES_US_13;
        4'he: wait_us = `BSTC_RES_US_14;
        4'hf: wait_us = `BSTC_RES_US_15;
      endcase
    end
  end

  assign wait_cycles_out = 12'(int'(wait_us) * `BSTC_CYC_PER_US);
  assign illegal_out = rotating_mass_mode_in && (code_in[3:2] != 2'h0);

endmodule : bstc_wait_lut

// ### bstc_top.sv
// Sensing wait timing registers and the measurement sequencer they steer
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "bstc_consts.svh"

module bstc_top #(
  parameter int DRIVE_STEP_CYCLES = `BSTC_DRIVE_STEP_CYC,
  parameter int COUNT_W = 17
) (
  input logic sys_clk_in,
  input logic sys_rst_in,
  input logic sys_ce_in,
  input bstc_pkg::bstc_bus_req_s bus_req_in,
  output logic [7:0] bus_rdata_out,
  input logic adc_valid_in,
  input logic [7:0] adc_data_in,
  output logic adc_start_out,
  output logic drive_active_out,
  output logic busy_out
);

  // ****************************************
  // Declarations
  // ****************************************
  bstc_pkg::bstc_state_e state_reg;
  bstc_pkg::bstc_state_e state_next;
  // Down counter sized for the longest rotating-mass drive window
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic count_load;
  logic [COUNT_W-1:0] drive_cycles;
  logic [COUNT_W-1:0] disch_cycles;
  logic [COUNT_W-1:0] settle_cycles;
  logic rotating_mass_mode_reg;
  logic continuous_reg;
  logic [4:0] drive_window_code_reg;
  logic [3:0] settle_wait_code_reg;
  logic [3:0] discharge_wait_code_reg;
  logic sample_ready_reg;
  logic [7:0] result_reg;
  logic adc_start_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] wait_code [2];
  logic [11:0] wait_cycles [2];
  logic [1:0] wait_illegal;
  logic cfg_error;
  logic wr_ctrl;
  logic wr_drive;
  logic wr_wait;
  logic wr_status;
  logic start_req;
  logic sample_taken;
  logic start_mode;

  // ****************************************
  // Write decode
  // ****************************************
  assign wr_ctrl = bus_req_in.wr && (bus_req_in.addr == `BSTC_ADDR_CTRL);
  assign wr_drive = bus_req_in.wr && (bus_req_in.addr == `BSTC_ADDR_DRIVE_WINDOW);
  assign wr_wait = bus_req_in.wr && (bus_req_in.addr == `BSTC_ADDR_SENSE_WAIT_TIMES);
  assign wr_status = bus_req_in.wr && (bus_req_in.addr == `BSTC_ADDR_STATUS);
  assign start_req = wr_ctrl && bus_req_in.wdata[`BSTC_CTRL_START_BIT];
  assign sample_taken = (state_reg == bstc_pkg::BSTC_SAMPLE) && adc_valid_in;

  // ****************************************
  // Actuator type for a starting drive window
  // ****************************************
  // A start that also changes the actuator type times its drive window with the new type
  assign start_mode = wr_ctrl ? bus_req_in.wdata[`BSTC_CTRL_RMM_BIT] : rotating_mass_mode_reg;

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rotating_mass_mode_reg <= 1'b0;
      continuous_reg <= 1'b0;
    end else if (sys_ce_in && wr_ctrl) begin
      rotating_mass_mode_reg <= bus_req_in.wdata[`BSTC_CTRL_RMM_BIT];
      continuous_reg <= bus_req_in.wdata[`BSTC_CTRL_CONT_BIT];
    end
  end

  // ****************************************
  // Drive window register
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      drive_window_code_reg <= `BSTC_RST_DRIVE_CODE;
    end else if (sys_ce_in && wr_drive) begin
      drive_window_code_reg <= bus_req_in.wdata[`BSTC_DRIVE_MSB:`BSTC_DRIVE_LSB];
    end
  end

  // ****************************************
  // Sense wait times register
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      settle_wait_code_reg <= `BSTC_RST_SETTLE_CODE;
      discharge_wait_code_reg <= `BSTC_RST_DISCH_CODE;
    end else if (sys_ce_in && wr_wait) begin
      settle_wait_code_reg <= bus_req_in.wdata[`BSTC_SETTLE_MSB:`BSTC_SETTLE_LSB];
      discharge_wait_code_reg <= bus_req_in.wdata[`BSTC_DISCH_MSB:`BSTC_DISCH_LSB];
    end
  end

  // ****************************************
  // Wait code lookup
  // ****************************************
  assign wait_code[0] = discharge_wait_code_reg;
  assign wait_code[1] = settle_wait_code_reg;

  // Entry 0 is the discharge wait, entry 1 the settle wait
  for (genvar i = 0; i < 2; i++) begin : g_wait
    bstc_wait_lut u_lut (
      .code_in(wait_code[i]),
      .rotating_mass_mode_in(rotating_mass_mode_reg),
      .wait_cycles_out(wait_cycles[i]),
      .illegal_out(wait_illegal[i])
    );
  end

  assign cfg_error = |wait_illegal;
  assign disch_cycles = COUNT_W'(wait_cycles[0]);
  assign settle_cycles = COUNT_W'(wait_cycles[1]);

  // Drive window: one step per code plus a fixed offset, doubled for rotating-mass
  assign drive_cycles = COUNT_W'((int'(drive_window_code_reg) + `BSTC_DRIVE_CODE_OFFSET)
                        * DRIVE_STEP_CYCLES
                        * (start_mode ? `BSTC_RMM_DRIVE_MULT : 1));

  // ****************************************
  // Measurement sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    count_load = 1'b0;
    count_next = '0;
    unique case (state_reg)
      bstc_pkg::BSTC_IDLE: begin
        if (start_req) begin
          state_next = bstc_pkg::BSTC_DRIVE;
          count_load = 1'b1;
          count_next = drive_cycles - COUNT_W'(1);
        end
      end
      bstc_pkg::BSTC_DRIVE: begin
        if (count_reg == '0) begin
          state_next = bstc_pkg::BSTC_DISCHARGE;
          count_load = 1'b1;
          count_next = disch_cycles - COUNT_W'(1);
        end
      end
      bstc_pkg::BSTC_DISCHARGE: begin
        if (count_reg == '0) begin
          state_next = bstc_pkg::BSTC_SETTLE;
          count_load = 1'b1;
          count_next = settle_cycles - COUNT_W'(1);
        end
      end
      bstc_pkg::BSTC_SETTLE: begin
        // Sample only once the settle count has run out
        if (count_reg == '0) begin
          state_next = bstc_pkg::BSTC_SAMPLE;
        end
      end
      bstc_pkg::BSTC_SAMPLE: begin
        if (adc_valid_in) begin
          if (continuous_reg) begin
            state_next = bstc_pkg::BSTC_DRIVE;
            count_load = 1'b1;
            count_next = drive_cycles - COUNT_W'(1);
          end else begin
            state_next = bstc_pkg::BSTC_IDLE;
          end
        end
      end
      default: begin
        state_next = bstc_pkg::BSTC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= bstc_pkg::BSTC_IDLE;
    end else if (sys_ce_in) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      count_reg <= '0;
    end else if (sys_ce_in) begin
      if (count_load) begin
        count_reg <= count_next;
      end else if (count_reg != '0) begin
        count_reg <= count_reg - COUNT_W'(1);
      end
    end
  end

  // ****************************************
  // Converter request and result
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      adc_start_reg <= 1'b0;
    end else if (sys_ce_in) begin
      adc_start_reg <= (state_reg == bstc_pkg::BSTC_SETTLE) && (count_reg == '0);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      result_reg <= 8'h00;
    end else if (sys_ce_in && sample_taken) begin
      result_reg <= adc_data_in;
    end
  end

  // New sample wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sample_ready_reg <= 1'b0;
    end else if (sys_ce_in) begin
      if (sample_taken) begin
        sample_ready_reg <= 1'b1;
      end else if (wr_status && bus_req_in.wdata[`BSTC_STAT_READY_BIT]) begin
        sample_ready_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // The write-only start bit and unmapped addresses read as zero
  always_comb begin
    rdata_next = 8'h00;
    if (bus_req_in.rd) begin
      unique case (bus_req_in.addr)
        `BSTC_ADDR_CTRL: begin
          rdata_next[`BSTC_CTRL_RMM_BIT] = rotating_mass_mode_reg;
          rdata_next[`BSTC_CTRL_CONT_BIT] = continuous_reg;
        end
        `BSTC_ADDR_DRIVE_WINDOW: begin
          rdata_next[`BSTC_DRIVE_MSB:`BSTC_DRIVE_LSB] = drive_window_code_reg;
        end
        `BSTC_ADDR_SENSE_WAIT_TIMES: begin
          rdata_next = {settle_wait_code_reg, discharge_wait_code_reg};
        end
        `BSTC_ADDR_STATUS: begin
          rdata_next[`BSTC_STAT_BUSY_BIT] = state_reg != bstc_pkg::BSTC_IDLE;
          rdata_next[`BSTC_STAT_STATE_MSB:`BSTC_STAT_STATE_LSB] = state_reg;
          rdata_next[`BSTC_STAT_READY_BIT] = sample_ready_reg;
          rdata_next[`BSTC_STAT_CFGERR_BIT] = cfg_error;
        end
        `BSTC_ADDR_RESULT: begin
          rdata_next = result_reg;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // Read data stand for exactly one enabled cycle after an enabled strobe
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 8'h00;
    end else if (sys_ce_in) begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus_rdata_out = rdata_reg;
  assign adc_start_out = adc_start_reg;
  assign drive_active_out = state_reg == bstc_pkg::BSTC_DRIVE;
  assign busy_out = state_reg != bstc_pkg::BSTC_IDLE;

endmodule : bstc_top

// ### bstc_checker.sv
// Port checker for the sensing wait timing block
`timescale 1ns/1ps
module bstc_checker #(
  parameter int DRIVE_STEP_CYCLES = 1000,
  parameter int COUNT_W = 17
) (
  input logic sys_clk_in,
  input logic sys_rst_in,
  input logic sys_ce_in,
  input bstc_pkg::bstc_bus_req_s bus_req_in,
  input logic [7:0] bus_rdata_out,
  input logic adc_valid_in,
  input logic [7:0] adc_data_in,
  input logic adc_start_out,
  input logic drive_active_out,
  input logic busy_out
);
  logic [7:0] wait_reg;
  logic [4:0] code_reg;
  int drv_exp_reg;
  int drv_cnt_reg;
  int busy_cnt_reg;
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = bus_req_in.wr && sys_ce_in;
  assign rd_ok = bus_req_in.rd && sys_ce_in;
  // ****************************************
  // Shadow of the written configuration
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wait_reg <= 8'h11;
      code_reg <= 5'h0a;
    end else if (wr_ok && bus_req_in.addr == 8'h28) begin
      wait_reg <= bus_req_in.wdata;
    end else if (wr_ok && bus_req_in.addr == 8'h27) begin
      code_reg <= bus_req_in.wdata[4:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (wr_ok && bus_req_in.addr == 8'h26 && bus_req_in.wdata[2] && !busy_out) begin
      drv_exp_reg <= (int'(code_reg) + 5) * DRIVE_STEP_CYCLES * (bus_req_in.wdata[0] ? 2 : 1);
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || sys_ce_in) begin
      drv_cnt_reg <= (drive_active_out && !sys_rst_in) ? drv_cnt_reg + 1 : 0;
      busy_cnt_reg <= (busy_out && !sys_rst_in) ? busy_cnt_reg + 1 : 0;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_wait_readback: assert property (rd_ok && bus_req_in.addr == 8'h28
    |=> bus_rdata_out == $past(wait_reg)) else $error("wait register readback wrong");
  a_unmapped_read: assert property (rd_ok && !(bus_req_in.addr inside
    {8'h26, 8'h27, 8'h28, 8'h2a, 8'h2b}) |=> bus_rdata_out == 8'h00) else $error("unmapped read");
  a_rdata_idle: assert property (sys_ce_in && !rd_ok |=> bus_rdata_out == 8'h00)
    else $error("read data not cleared");
  a_drive_length: assert property ($fell(drive_active_out) |-> drv_cnt_reg == drv_exp_reg)
    else $error("drive window length wrong");
  a_drive_first: assert property ($rose(busy_out) |-> drive_active_out)
    else $error("measurement did not begin with drive");
  a_sample_waits: assert property (adc_start_out |-> busy_out && !drive_active_out
    && busy_cnt_reg >= 300) else $error("sample requested too early");
  a_start_pulse: assert property (adc_start_out |=> !adc_start_out)
    else $error("sample request longer than one cycle");
  a_busy_release: assert property ($fell(busy_out) |-> $past(adc_valid_in))
    else $error("idle before sample arrived");
  c_drive_done: cover property ($fell(drive_active_out));
  c_sample_req: cover property (adc_start_out);
  c_wait_read: cover property (rd_ok && bus_req_in.addr == 8'h28);
endmodule : bstc_checker

bind bstc_top bstc_checker #(.DRIVE_STEP_CYCLES(DRIVE_STEP_CYCLES), .COUNT_W(COUNT_W)) u_chk (
  .sys_clk_in, .sys_rst_in, .sys_ce_in, .bus_req_in, .bus_rdata_out, .adc_valid_in,
  .adc_data_in, .adc_start_out, .drive_active_out, .busy_out
);

// ### bstc_top_test.sv
// Self-checking bench for the sensing wait timing block
`timescale 1ns/1ps
module bstc_top_test;
  localparam int STEP = 2;
  logic sys_clk_in, sys_rst_in, sys_ce_in, adc_valid_in;
  logic adc_start_out, drive_active_out, busy_out, rd_seen;
  logic [7:0] adc_data_in, bus_rdata_out;
  bstc_pkg::bstc_bus_req_s bus_req_in;
  int err_total, num_checks, lat_cnt;
  logic [7:0] exp_rd_q[$];
  int exp_lat_q[$];
  int res_us[16] = '{15, 25, 50, 75, 90, 105, 120, 135, 150, 165, 180, 195, 210, 235, 260, 285};
  int rmm_us[4] = '{45, 75, 150, 225};

  bstc_top #(.DRIVE_STEP_CYCLES(STEP)) u_dut (
    .sys_clk_in, .sys_rst_in, .sys_ce_in, .bus_req_in, .bus_rdata_out, .adc_valid_in,
    .adc_data_in, .adc_start_out, .drive_active_out, .busy_out
  );

  // ****************************************
  // Compare, bus and closing tasks
  // ****************************************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t read %h want %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_lat(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("ERROR %0t latency %0d want %0d", $time, got, exp);
    end
  endtask : chk_lat
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    bus_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    bus_req_in <= '0;
    @(posedge sys_clk_in);
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd_q.push_back(e);
    bus_req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    bus_req_in <= '0;
    @(posedge sys_clk_in);
  endtask : bus_rd
  task automatic tally_and_finish;
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // One measurement, then the stored sample and its ready flag
  task automatic measure(input logic mode, input int dc, input int sc, input int drv);
    int w;
    int k;
    logic [7:0] d;
    d = 8'($urandom);
    k = $urandom_range(1, 3);
    bus_wr(8'h27, 8'(drv));
    bus_wr(8'h28, 8'(sc * 16 + dc));
    exp_lat_q.push_back((drv + 5) * STEP * (mode ? 2 : 1) + 1 + k
      + 10 * (mode ? rmm_us[dc % 4] + rmm_us[sc % 4] : res_us[dc] + res_us[sc]));
    bus_wr(8'h26, {7'h02, mode});
    // Freeze the block for k cycles inside the drive window; the answer moves by k
    sys_ce_in <= 1'b0;
    repeat (k) @(posedge sys_clk_in);
    sys_ce_in <= 1'b1;
    w = 0;
    while (adc_start_out !== 1'b1 && w < 8000) begin
      @(posedge sys_clk_in);
      w++;
    end
    repeat ($urandom_range(0, 3)) @(posedge sys_clk_in);
    adc_valid_in <= 1'b1;
    adc_data_in <= d;
    @(posedge sys_clk_in);
    adc_valid_in <= 1'b0;
    @(posedge sys_clk_in);
    bus_rd(8'h2a, 8'h10);
    bus_rd(8'h2b, d);
    bus_wr(8'h2a, 8'h10);
    bus_rd(8'h2a, 8'h00);
  endtask : measure

  // ****************************************
  // Clock, monitor, watchdog and main sequence
  // ****************************************
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    if (rd_seen) chk_byte(bus_rdata_out, exp_rd_q.pop_front());
    rd_seen = bus_req_in.rd && !sys_rst_in;
    if (bus_req_in.wr && bus_req_in.addr == 8'h26 && bus_req_in.wdata[2] && !busy_out) lat_cnt = 0;
    else lat_cnt++;
    if (adc_start_out === 1'b1) chk_lat(lat_cnt, exp_lat_q.pop_front());
  end
  initial begin
    repeat (80000) @(posedge sys_clk_in);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    logic [7:0] v;
    sys_rst_in = 1'b1;
    sys_ce_in = 1'b1;
    adc_valid_in = 1'b0;
    adc_data_in = 8'h00;
    bus_req_in = '0;
    rd_seen = 1'b0;
    lat_cnt = 0;
    void'($urandom(93032));
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    bus_rd(8'h28, 8'h11);
    bus_rd(8'h27, 8'h0a);
    bus_wr(8'h55, 8'hff);
    bus_rd(8'h55, 8'h00);
    bus_wr(8'h2b, 8'h5a);
    bus_rd(8'h2b, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      bus_wr(8'h28, v);
      bus_rd(8'h28, v);
    end
    for (int i = 0; i < 16; i++) begin
      measure(1'b0, 15 - i, i, 24 + i % 8);
    end
    for (int i = 0; i < 4; i++) begin
      measure(1'b1, 3 - i, i, 28 + i);
    end
    chk_lat(exp_lat_q.size(), 0);
    tally_and_finish();
  end
endmodule : bstc_top_test
